/* File: axfr_pkg.sv */
package axfr_pkg;
  // -----------------------------------------------------------------
  // register offsets
  // -----------------------------------------------------------------
  localparam logic [7:0] KEY_ADDR = 8'h80;
  localparam logic [7:0] Y_AXIS_FILTER_CONFIG_ADDR = 8'h87;
  localparam logic [7:0] Z_SELFTEST_ADDR = 8'h88;
  localparam logic [7:0] Z_AXIS_FILTER_CONFIG_ADDR = 8'h89;
  localparam logic [7:0] X_LOW_ADDR = 8'h8a;
  localparam logic [7:0] X_HIGH_ADDR = 8'h8b;
  localparam logic [7:0] Y_LOW_ADDR = 8'h8c;
  localparam logic [7:0] Y_HIGH_ADDR = 8'h8d;
  localparam logic [7:0] Z_LOW_ADDR = 8'h8e;
  localparam logic [7:0] Z_HIGH_ADDR = 8'h8f;
  // -----------------------------------------------------------------
  // key values and reset values
  // -----------------------------------------------------------------
  localparam logic [7:0] KEY_FIRST = 8'hbc;
  localparam logic [7:0] KEY_SECOND = 8'h43;
  localparam logic [7:0] KEY_READBACK = 8'hbc;
  localparam logic [7:0] FILT_RESET = 8'h40;
  localparam logic [7:0] SELFTEST_RESET = 8'h00;
  // -----------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------
  localparam int HP_EN_BIT = 7;
  localparam int IIR_EN_BIT = 6;
  localparam int HP_CORNER_MSB = 5;
  localparam int HP_CORNER_LSB = 4;
  localparam int IIR_CORNER_MSB = 3;
  localparam int IIR_CORNER_LSB = 2;
  localparam int DEC_CORNER_MSB = 1;
  localparam int DEC_CORNER_LSB = 0;
  localparam int ST_SQUARE_BIT = 2;
  localparam int ST_POS_BIT = 1;
  localparam int ST_NEG_BIT = 0;
  localparam int SAMPLE_WIDTH = 14;
  localparam int AXES = 3;
  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam longint CLOCK_HZ = 10000000;
  localparam longint SQUARE_HZ = 100;
  localparam int SQUARE_HALF_CYCLES = int'(CLOCK_HZ / (2 * SQUARE_HZ));
  // -----------------------------------------------------------------
  // types
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    AXFR_LOCKED = 2'b00,
    AXFR_HALF = 2'b01,
    AXFR_OPEN = 2'b10
  } axfr_lock_type;
  typedef enum logic [1:0] {
    AXFR_ST_NONE = 2'b00,
    AXFR_ST_POS = 2'b01,
    AXFR_ST_NEG = 2'b10
  } axfr_stim_type;
endpackage

/* File: axfr_stim_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface axfr_stim_if;
  logic [7:0] select;
  axfr_pkg::axfr_stim_type stim;
  modport ctrl (output select, input stim);
  modport gen (input select, output stim);
endinterface
`default_nettype wire

/* File: axfr_selftest_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module axfr_selftest_gen (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  axfr_stim_if.gen st
);
  // -----------------------------------------------------------------
  // square wave timer
  // -----------------------------------------------------------------
  logic [19:0] count;
  logic phase;
  logic wrap;
  logic sq_only;
  logic pos_only;
  logic neg_only;
  assign wrap = (count == 20'(axfr_pkg::SQUARE_HALF_CYCLES - 1));
  assign sq_only = (st.select[2:0] == 3'h4);
  assign pos_only = (st.select[2:0] == 3'h2);
  assign neg_only = (st.select[2:0] == 3'h1);
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count <= 20'h0_0000;
      phase <= 1'b0;
    end else if (!sq_only || wrap) begin
      count <= 20'h0_0000;
      phase <= sq_only ? ~phase : 1'b0;
    end else begin
      count <= count + 20'h0_0001;
    end
  end
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st.stim <= axfr_pkg::AXFR_ST_NONE;
    end else if (pos_only || (sq_only && phase)) begin
      st.stim <= axfr_pkg::AXFR_ST_POS;
    end else if (neg_only || (sq_only && !phase)) begin
      st.stim <= axfr_pkg::AXFR_ST_NEG;
    end else begin
      st.stim <= axfr_pkg::AXFR_ST_NONE;
    end
  end
endmodule
`default_nettype wire

/* File: axfr_regs.sv */
// Contract
// - bit 7 inserts high-pass, reset bypassed
// - bit 6 inserts IIR, reset active
// - bits 5:4 select high-pass corner
// - bits 3:2 select IIR corner
// - bits 1:0 select decimator corner
// - filter registers reset to 0x40
// - y filter 0x87, z filter 0x89
// - z self-test bits 2,1,0, reset zero
// - several test bits set: no stimulus
// - square-wave test at 100 Hz
// - positive or negative constant stimulus
// - 14-bit left-justified, low two zero
// - low byte six lsbs, high eight msbs
// - data bytes at 0x8A to 0x8F
// - writes ignored until key 0xBC,0x43
// - unlocked key reads 0xBC
`timescale 1ns/1ps
`default_nettype none
module axfr_regs (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [13:0] x_sample_i,
  input wire logic [13:0] y_sample_i,
  input wire logic [13:0] z_sample_i,
  output logic [7:0] rdata_o,
  output logic unlocked_o,
  output logic y_highpass_enable_o,
  output logic y_recursive_filter_enable_o,
  output logic [1:0] y_highpass_corner_sel_o,
  output logic [1:0] y_recursive_corner_sel_o,
  output logic [1:0] y_decimator_corner_sel_o,
  output logic z_highpass_enable_o,
  output logic z_recursive_filter_enable_o,
  output logic [1:0] z_highpass_corner_sel_o,
  output logic [1:0] z_recursive_corner_sel_o,
  output logic [1:0] z_decimator_corner_sel_o,
  output logic z_square_wave_test_en_o,
  output logic z_positive_static_test_en_o,
  output logic z_negative_static_test_en_o,
  output logic [1:0] z_stimulus_o
);
  // -----------------------------------------------------------------
  // storage
  // -----------------------------------------------------------------
  axfr_pkg::axfr_lock_type lock_state;
  axfr_pkg::axfr_lock_type next_lock_state;
  logic [7:0] y_axis_filter_config;
  logic [7:0] z_axis_filter_config;
  logic [7:0] z_axis_selftest_select;
  logic [7:0] held_high [axfr_pkg::AXES];
  logic [13:0] sample [axfr_pkg::AXES];
  logic [7:0] low_byte [axfr_pkg::AXES];
  logic [7:0] high_byte [axfr_pkg::AXES];
  logic [axfr_pkg::AXES-1:0] low_hit;
  logic [axfr_pkg::AXES-1:0] high_hit;
  logic open;
  logic key_wr;
  logic wr_y_axis_filter_config;
  logic wr_z_axis_filter_config;
  logic wr_z_st;
  logic [7:0] next_rdata;
  axfr_stim_if st_bus ();

  assign sample[0] = x_sample_i;
  assign sample[1] = y_sample_i;
  assign sample[2] = z_sample_i;

  // -----------------------------------------------------------------
  // write unlock sequence
  // -----------------------------------------------------------------
  assign key_wr = wr_en_i && (addr_i == axfr_pkg::KEY_ADDR);
  assign open = (lock_state == axfr_pkg::AXFR_OPEN);

  always_comb begin
    next_lock_state = lock_state;
    case (lock_state)
      axfr_pkg::AXFR_LOCKED: begin
        if (key_wr && wdata_i == axfr_pkg::KEY_FIRST) begin
          next_lock_state = axfr_pkg::AXFR_HALF;
        end
      end
      axfr_pkg::AXFR_HALF: begin
        if (key_wr && wdata_i == axfr_pkg::KEY_SECOND) begin
          next_lock_state = axfr_pkg::AXFR_OPEN;
        end else if (key_wr && wdata_i != axfr_pkg::KEY_FIRST) begin
          next_lock_state = axfr_pkg::AXFR_LOCKED;
        end else if (wr_en_i && !key_wr) begin
          next_lock_state = axfr_pkg::AXFR_LOCKED;
        end
      end
      axfr_pkg::AXFR_OPEN: begin
        next_lock_state = axfr_pkg::AXFR_OPEN;
      end
      default: begin
        next_lock_state = axfr_pkg::AXFR_LOCKED;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lock_state <= axfr_pkg::AXFR_LOCKED;
    end else begin
      lock_state <= next_lock_state;
    end
  end

  // -----------------------------------------------------------------
  // write decode
  // -----------------------------------------------------------------
  // filter and self-test register decode
  assign wr_y_axis_filter_config = open && wr_en_i && (addr_i == axfr_pkg::Y_AXIS_FILTER_CONFIG_ADDR);
  assign wr_z_axis_filter_config = open && wr_en_i && (addr_i == axfr_pkg::Z_AXIS_FILTER_CONFIG_ADDR);
  assign wr_z_st = open && wr_en_i && (addr_i == axfr_pkg::Z_SELFTEST_ADDR);

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      y_axis_filter_config <= axfr_pkg::FILT_RESET;
    end else if (wr_y_axis_filter_config) begin
      y_axis_filter_config <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      z_axis_filter_config <= axfr_pkg::FILT_RESET;
    end else if (wr_z_axis_filter_config) begin
      z_axis_filter_config <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      z_axis_selftest_select <= axfr_pkg::SELFTEST_RESET;
    end else if (wr_z_st) begin
      z_axis_selftest_select <= wdata_i;
    end
  end

  // -----------------------------------------------------------------
  // sample formatting and coherent high byte
  // -----------------------------------------------------------------
  genvar a;
  generate
    for (a = 0; a < axfr_pkg::AXES; a++) begin : g_axis
      // six lsbs up, eight msbs high
      assign low_byte[a] = {sample[a][5:0], 2'b00};
      assign high_byte[a] = sample[a][13:6];
      assign low_hit[a] = (addr_i == 8'(axfr_pkg::X_LOW_ADDR + 8'(2 * a)));
      assign high_hit[a] = (addr_i == 8'(axfr_pkg::X_HIGH_ADDR + 8'(2 * a)));
      always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          held_high[a] <= 8'h00;
        end else if (rd_en_i && low_hit[a]) begin
          held_high[a] <= high_byte[a];
        end
      end
    end
  endgenerate

  // -----------------------------------------------------------------
  // read mux
  // -----------------------------------------------------------------
  // data bytes have no write path
  always_comb begin
    next_rdata = 8'h00;
    case (addr_i)
      axfr_pkg::KEY_ADDR: next_rdata = open ? axfr_pkg::KEY_READBACK : 8'h00;
      axfr_pkg::Y_AXIS_FILTER_CONFIG_ADDR: next_rdata = y_axis_filter_config;
      axfr_pkg::Z_SELFTEST_ADDR: next_rdata = z_axis_selftest_select;
      axfr_pkg::Z_AXIS_FILTER_CONFIG_ADDR: next_rdata = z_axis_filter_config;
      axfr_pkg::X_LOW_ADDR: next_rdata = low_byte[0];
      axfr_pkg::X_HIGH_ADDR: next_rdata = held_high[0];
      axfr_pkg::Y_LOW_ADDR: next_rdata = low_byte[1];
      axfr_pkg::Y_HIGH_ADDR: next_rdata = held_high[1];
      axfr_pkg::Z_LOW_ADDR: next_rdata = low_byte[2];
      axfr_pkg::Z_HIGH_ADDR: next_rdata = held_high[2];
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_en_i) begin
      rdata_o <= next_rdata;
    end
  end

  // -----------------------------------------------------------------
  // control outputs
  // -----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      unlocked_o <= 1'b0;
      y_highpass_enable_o <= 1'b0;
      y_recursive_filter_enable_o <= 1'b1;
      y_highpass_corner_sel_o <= 2'h0;
      y_recursive_corner_sel_o <= 2'h0;
      y_decimator_corner_sel_o <= 2'h0;
      z_highpass_enable_o <= 1'b0;
      z_recursive_filter_enable_o <= 1'b1;
      z_highpass_corner_sel_o <= 2'h0;
      z_recursive_corner_sel_o <= 2'h0;
      z_decimator_corner_sel_o <= 2'h0;
      z_square_wave_test_en_o <= 1'b0;
      z_positive_static_test_en_o <= 1'b0;
      z_negative_static_test_en_o <= 1'b0;
      z_stimulus_o <= 2'h0;
    end else begin
      unlocked_o <= open;
      y_highpass_enable_o <= y_axis_filter_config[axfr_pkg::HP_EN_BIT];
      z_highpass_enable_o <= z_axis_filter_config[axfr_pkg::HP_EN_BIT];
      y_recursive_filter_enable_o <=
        y_axis_filter_config[axfr_pkg::IIR_EN_BIT];
      z_recursive_filter_enable_o <=
        z_axis_filter_config[axfr_pkg::IIR_EN_BIT];
      y_highpass_corner_sel_o <=
        y_axis_filter_config[axfr_pkg::HP_CORNER_MSB:axfr_pkg::HP_CORNER_LSB];
      z_highpass_corner_sel_o <=
        z_axis_filter_config[axfr_pkg::HP_CORNER_MSB:axfr_pkg::HP_CORNER_LSB];
      y_recursive_corner_sel_o <=
        y_axis_filter_config[axfr_pkg::IIR_CORNER_MSB:axfr_pkg::IIR_CORNER_LSB];
      z_recursive_corner_sel_o <=
        z_axis_filter_config[axfr_pkg::IIR_CORNER_MSB:axfr_pkg::IIR_CORNER_LSB];
      y_decimator_corner_sel_o <=
        y_axis_filter_config[axfr_pkg::DEC_CORNER_MSB:axfr_pkg::DEC_CORNER_LSB];
      z_decimator_corner_sel_o <=
        z_axis_filter_config[axfr_pkg::DEC_CORNER_MSB:axfr_pkg::DEC_CORNER_LSB];
      z_square_wave_test_en_o <=
        z_axis_selftest_select[axfr_pkg::ST_SQUARE_BIT];
      z_positive_static_test_en_o <=
        z_axis_selftest_select[axfr_pkg::ST_POS_BIT];
      z_negative_static_test_en_o <=
        z_axis_selftest_select[axfr_pkg::ST_NEG_BIT];
      z_stimulus_o <= st_bus.stim;
    end
  end

  // -----------------------------------------------------------------
  // self-test stimulus generator
  // -----------------------------------------------------------------
  assign st_bus.select = z_axis_selftest_select;

  axfr_selftest_gen u_selftest (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .st(st_bus.gen)
  );
endmodule
`default_nettype wire

/* File: axfr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module axfr_host_model #(
  parameter int SETTLE_CYCLES = 16
) (
  input wire logic mclk_i,
  input wire logic [7:0] rdata_i,
  output logic wr_en_o,
  output logic rd_en_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  bit settle = 1'b0;
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    #1;
    wr_en_o = 1'b1;
    addr_o = a;
    wdata_o = d;
    @(posedge mclk_i);
    #1;
    wr_en_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
    settle = settle | (a == 8'h80 && d == 8'h43);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    if (settle && a >= 8'h8a && a <= 8'h8f) begin
      repeat (SETTLE_CYCLES) @(posedge mclk_i);
      settle = 1'b0;
    end
    @(posedge mclk_i);
    #1;
    rd_en_o = 1'b1;
    addr_o = a;
    @(posedge mclk_i);
    #1;
    rd_en_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

/* File: axfr_regs_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module axfr_regs_chk (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [13:0] y_sample_i,
  input wire logic [7:0] rdata_o,
  input wire logic unlocked_o,
  input wire logic y_highpass_enable_o,
  input wire logic y_recursive_filter_enable_o,
  input wire logic [1:0] y_highpass_corner_sel_o,
  input wire logic [1:0] y_recursive_corner_sel_o,
  input wire logic [1:0] y_decimator_corner_sel_o,
  input wire logic z_square_wave_test_en_o,
  input wire logic z_positive_static_test_en_o,
  input wire logic z_negative_static_test_en_o,
  input wire logic [1:0] z_stimulus_o
);
  wire logic [7:0] ycfg = {y_highpass_enable_o, y_recursive_filter_enable_o,
    y_highpass_corner_sel_o, y_recursive_corner_sel_o,
    y_decimator_corner_sel_o};
  wire logic [2:0] st = {z_square_wave_test_en_o,
    z_positive_static_test_en_o, z_negative_static_test_en_o};
  wire logic [5:0] y_lo = y_sample_i[5:0];
  wire logic [7:0] y_hi = y_sample_i[13:6];
  wire logic wr_y = wr_en_i && unlocked_o && addr_i == 8'h87;
  wire logic st_many = $countones(st) > 1;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_key;
    wr_en_i && addr_i == 8'h80 && wdata_i == 8'hbc ##1 !wr_en_i
    ##1 wr_en_i && addr_i == 8'h80 && wdata_i == 8'h43;
  endsequence
  sequence s_pair;
    rd_en_i && addr_i == 8'h8c ##1 !rd_en_i ##1 rd_en_i && addr_i == 8'h8d;
  endsequence
  property p_unlock; s_key |-> ##2 unlocked_o; endproperty
  a_unlock: assert property (p_unlock) else $error("no unlock");
  property p_hold; unlocked_o |=> unlocked_o; endproperty
  a_hold: assert property (p_hold) else $error("unlock lost");
  property p_locked; !unlocked_o |-> ycfg == 8'h40 && st == 3'b000; endproperty
  a_locked: assert property (p_locked) else $error("locked change");
  property p_ywrite; wr_y |-> ##2 ycfg == $past(wdata_i, 2); endproperty
  a_ywrite: assert property (p_ywrite) else $error("y filter");
  property p_keyrd;
    rd_en_i && addr_i == 8'h80 && unlocked_o |=> rdata_o == 8'hbc;
  endproperty
  a_keyrd: assert property (p_keyrd) else $error("key readback");
  property p_low;
    rd_en_i && addr_i == 8'h8c |=> rdata_o == {$past(y_lo), 2'b00};
  endproperty
  a_low: assert property (p_low) else $error("low byte");
  property p_pair; s_pair |=> rdata_o == $past(y_hi, 3); endproperty
  a_pair: assert property (p_pair) else $error("high byte");
  property p_many; st_many [*2] |-> z_stimulus_o == 2'b00; endproperty
  a_many: assert property (p_many) else $error("stim conflict");
  property p_pos; (st == 3'b010) [*2] |-> z_stimulus_o == 2'b01; endproperty
  a_pos: assert property (p_pos) else $error("stim positive");
  property p_neg; (st == 3'b001) [*2] |-> z_stimulus_o == 2'b10; endproperty
  a_neg: assert property (p_neg) else $error("stim negative");
endmodule
bind axfr_regs axfr_regs_chk chk (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
  .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .y_sample_i(y_sample_i), .rdata_o(rdata_o), .unlocked_o(unlocked_o),
  .y_highpass_enable_o(y_highpass_enable_o),
  .y_recursive_filter_enable_o(y_recursive_filter_enable_o),
  .y_highpass_corner_sel_o(y_highpass_corner_sel_o),
  .y_recursive_corner_sel_o(y_recursive_corner_sel_o),
  .y_decimator_corner_sel_o(y_decimator_corner_sel_o),
  .z_square_wave_test_en_o(z_square_wave_test_en_o),
  .z_positive_static_test_en_o(z_positive_static_test_en_o),
  .z_negative_static_test_en_o(z_negative_static_test_en_o),
  .z_stimulus_o(z_stimulus_o));
`default_nettype wire

/* File: test_accel_axis_filter_selftest_data_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module test_accel_axis_filter_selftest_data_regs;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [13:0] smp [3] = '{14'h0000, 14'h0000, 14'h0000};
  wire logic wr_en, rd_en, unl_o;
  wire logic [7:0] addr, wdata, rdata, ycfg, zcfg;
  wire logic [2:0] st;
  wire logic [1:0] stim;
  logic [7:0] yf, zs, zf;
  logic [7:0] hi [3];
  bit unl, kst;
  int error_cnt = 0;
  int cmp_count = 0;
  always #50 clk = ~clk;
  axfr_host_model host (.mclk_i(clk), .rdata_i(rdata), .wr_en_o(wr_en),
    .rd_en_o(rd_en), .addr_o(addr), .wdata_o(wdata));
  axfr_regs uut (.mclk_i(clk), .reset_n_i(rst_n), .wr_en_i(wr_en),
    .rd_en_i(rd_en), .addr_i(addr), .wdata_i(wdata), .x_sample_i(smp[0]),
    .y_sample_i(smp[1]), .z_sample_i(smp[2]), .rdata_o(rdata),
    .unlocked_o(unl_o), .y_highpass_enable_o(ycfg[7]),
    .y_recursive_filter_enable_o(ycfg[6]),
    .y_highpass_corner_sel_o(ycfg[5:4]),
    .y_recursive_corner_sel_o(ycfg[3:2]),
    .y_decimator_corner_sel_o(ycfg[1:0]), .z_highpass_enable_o(zcfg[7]),
    .z_recursive_filter_enable_o(zcfg[6]),
    .z_highpass_corner_sel_o(zcfg[5:4]),
    .z_recursive_corner_sel_o(zcfg[3:2]),
    .z_decimator_corner_sel_o(zcfg[1:0]), .z_square_wave_test_en_o(st[2]),
    .z_positive_static_test_en_o(st[1]),
    .z_negative_static_test_en_o(st[0]), .z_stimulus_o(stim));
  task automatic cmp(input string nm, input logic [15:0] e,
      input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic mreset();
    yf = 8'h40;
    zf = 8'h40;
    zs = 8'h00;
    unl = 1'b0;
    kst = 1'b0;
    hi = '{8'h00, 8'h00, 8'h00};
  endtask
  task automatic wr_m(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    if (a == 8'h80) begin
      unl = unl | (kst && d == 8'h43);
      kst = (d == 8'hbc);
    end else begin
      kst = 1'b0;
      if (unl && a == 8'h87) yf = d;
      if (unl && a == 8'h88) zs = d;
      if (unl && a == 8'h89) zf = d;
    end
  endtask
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h80: exp_rd = unl ? 8'hbc : 8'h00;
      8'h87: exp_rd = yf;
      8'h88: exp_rd = zs;
      8'h89: exp_rd = zf;
      8'h8a, 8'h8c, 8'h8e: exp_rd = {smp[(a - 8'h8a) >> 1][5:0], 2'b00};
      8'h8b, 8'h8d, 8'h8f: exp_rd = hi[(a - 8'h8b) >> 1];
      default: exp_rd = 8'h00;
    endcase
  endfunction
  task automatic rd_chk(input logic [7:0] a);
    logic [7:0] e, d;
    e = exp_rd(a);
    host.rd(a, d);
    if (a inside {8'h8a, 8'h8c, 8'h8e}) begin
      hi[(a - 8'h8a) >> 1] = smp[(a - 8'h8a) >> 1][13:6];
    end
    cmp("rdata", 16'(e), 16'(d));
  endtask
  task automatic rd_all();
    for (int i = 0; i < 20; i++) begin
      smp = '{14'($urandom), 14'($urandom), 14'($urandom)};
      rd_chk(8'h7e + 8'(i));
    end
  endtask
  task automatic chk_out();
    logic [1:0] es;
    es = zs[2:0] == 3'b010 ? 2'b01 : (zs[2:0] == 3'b001 ? 2'b10 : 2'b00);
    repeat (3) @(posedge clk);
    #1;
    cmp("y_cfg", 16'(yf), 16'(ycfg));
    cmp("z_cfg", 16'(zf), 16'(zcfg));
    cmp("z_select", 16'(zs[2:0]), 16'(st));
    if (zs[2:0] != 3'b100) cmp("z_stim", 16'(es), 16'(stim));
    cmp("unlocked", 16'(unl), 16'(unl_o));
  endtask
  initial begin
    logic [7:0] a;
    int n;
    void'($urandom(49));
    mreset();
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk_out();
    wr_m(8'h87, 8'hff);
    wr_m(8'h80, 8'hbc);
    wr_m(8'h89, 8'h00);
    wr_m(8'h80, 8'h43);
    chk_out();
    rd_all();
    wr_m(8'h80, 8'hbc);
    wr_m(8'h80, 8'hbc);
    wr_m(8'h80, 8'h43);
    chk_out();
    rd_all();
    for (int i = 0; i < 4; i++) begin
      wr_m(8'h89, {2'b10, 2'(i), 2'(i), 2'(i)});
      chk_out();
    end
    for (int i = 0; i < 24; i++) begin
      a = 8'h87 + 8'($urandom_range(0, 8));
      wr_m(a, 8'($urandom));
      rd_chk(a);
      chk_out();
    end
    for (int i = 0; i < 8; i++) begin
      if (i != 4) wr_m(8'h88, {5'($urandom), 3'(i)});
      if (i != 4) chk_out();
    end
    wr_m(8'h88, 8'h04);
    n = 0;
    while (stim !== 2'b10 && n < 10) begin
      @(posedge clk);
      #1;
      n++;
    end
    n = 0;
    while (stim === 2'b10 && n < 60000) begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp("half", 16'(axfr_pkg::SQUARE_HALF_CYCLES), 16'(n));
    rst_n = 1'b0;
    mreset();
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk_out();
    rd_chk(8'h80);
    end_sim();
  end
  initial begin
    #9000000;
    error_cnt++;
    end_sim();
  end
endmodule
`default_nettype wire
